// file: include/iol_regs.svh
// Register offsets, field positions, reset values and timing counts of the I/O line control block
`ifndef IOL_REGS_SVH
`define IOL_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define IOL_OFS_LINE_SEL 12'h000
`define IOL_OFS_LINE_CFG 12'h004
`define IOL_OFS_STATE_LO 12'h008
`define IOL_OFS_STATE_HI 12'h00C
`define IOL_OFS_LINE_STATE 12'h010

// ----------------------------------------------------------------------
// Line configuration field positions
// ----------------------------------------------------------------------
`define IOL_CFG_INV_BIT 0
`define IOL_CFG_LVL_LSB 1
`define IOL_CFG_MODE_LSB 4
`define IOL_CFG_BAL_BIT 6
`define IOL_CFG_SRC_LSB 8
`define IOL_CFG_STYLE_LSB 16
`define IOL_CFG_KIND_LSB 18
`define IOL_CFG_STATE_BIT 24

// ----------------------------------------------------------------------
// Line map and reset values
// ----------------------------------------------------------------------
`define IOL_NUM_LINES 40
`define IOL_FIRST_ISO_IN 6'd4
`define IOL_FIRST_ISO_OUT 6'd12
`define IOL_FIRST_BIDIR 6'd16
`define IOL_FIRST_EXT 6'd20
`define IOL_LVL_RST 3'h1
`define IOL_OE_N_RST 40'hFF_FFFF_0FFF

// ----------------------------------------------------------------------
// Filter time constants
// ----------------------------------------------------------------------
`define IOL_CLK_PERIOD_NS 10
`define IOL_TC_FAST_0_NS 50
`define IOL_TC_FAST_1_NS 100
`define IOL_TC_FAST_2_NS 200
`define IOL_TC_FAST_3_NS 500
`define IOL_TC_FAST_4_NS 1000
`define IOL_TC_ISO_0_NS 500
`define IOL_TC_ISO_1_NS 1000
`define IOL_TC_ISO_2_NS 2000
`define IOL_TC_ISO_3_NS 5000
`define IOL_TC_ISO_4_NS 10000
`define IOL_CYC(ns) (((ns) + `IOL_CLK_PERIOD_NS - 1) / `IOL_CLK_PERIOD_NS)

`endif

// file: include/iol_pkg.sv
// Types of the I/O line control block
package iol_pkg;

   typedef enum logic [1:0] {IOL_KIND_BAL_IN, IOL_KIND_ISO_IN, IOL_KIND_ISO_OUT, IOL_KIND_BIDIR} iol_kind_e;
   typedef enum logic [1:0] {IOL_STYLE_BAL, IOL_STYLE_OPTO, IOL_STYLE_TTL} iol_style_e;
   typedef enum logic [1:0] {IOL_MODE_INPUT, IOL_MODE_OUTPUT, IOL_MODE_SINK_ONLY, IOL_MODE_SOURCE_ONLY} iol_mode_e;

   // Source choice: group in the top two bits, index in the low six
   typedef enum logic [1:0] {IOL_SRC_LOW, IOL_SRC_USER, IOL_SRC_STROBE, IOL_SRC_TRIG} iol_src_grp_e;

   typedef struct packed
   {
      logic [31:0] user_bits;
      logic [7:0] strobe;
      logic [7:0] cam_trig;
   } iol_sources_s;

   typedef struct packed
   {
      logic [39:0] tx_level;
      logic [39:0] tx_oe_n;
   } iol_pins_s;

   typedef struct packed
   {
      logic [39:0] sync1;
      logic [39:0] sync2;
      logic [39:0] filt;
      logic [39:0][9:0] cnt;
      logic [39:0] inv;
      logic [39:0][2:0] lvl;
      logic [39:0][1:0] mode;
      logic [39:0] bal;
      logic [39:0][7:0] src;
      logic [39:0] srclvl;
      logic [5:0] sel;
      iol_pins_s pins;
   } iol_state_s;

endpackage

// file: hw/iol_line_ctrl.sv
// I/O line control block: per-line inverter, glitch filter, source mux, driver and APB registers
module iol_line_ctrl
   import iol_pkg::*;
#(
   parameter int NUM_USER = 32,
   parameter int NUM_STROBE = 8,
   parameter int NUM_TRIG = 8
)
(
   // Clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Internal output sources
   input wire iol_sources_s sources,
   // Line pins
   input wire logic [39:0] rx_pin,
   output iol_pins_s pins,
   // All-lines state word
   output logic [39:0] all_lines_state_word
);

`include "iol_regs.svh"

   // ----------------------------------------------------------------------
   // Line map decoding
   // ----------------------------------------------------------------------
   // Lines 0-3 balanced inputs (set 2 balanced pair at bits 2-3), 4-11 isolated inputs,
   // 12-15 isolated outputs, 16-19 LVTTL bidir, 20-39 extension module lines
   function automatic iol_kind_e line_kind(input logic [5:0] idx);
      iol_kind_e k;
      k = IOL_KIND_BAL_IN;
      if (idx >= `IOL_FIRST_EXT)
      begin
         k = IOL_KIND_BIDIR;
      end
      else if (idx >= `IOL_FIRST_BIDIR)
      begin
         k = IOL_KIND_BIDIR;
      end
      else if (idx >= `IOL_FIRST_ISO_OUT)
      begin
         k = IOL_KIND_ISO_OUT;
      end
      else if (idx >= `IOL_FIRST_ISO_IN)
      begin
         k = IOL_KIND_ISO_IN;
      end
      return k;
   endfunction

   function automatic logic is_ext(input logic [5:0] idx);
      return idx >= `IOL_FIRST_EXT;
   endfunction

   function automatic logic is_lvttl(input logic [5:0] idx);
      return (idx >= `IOL_FIRST_BIDIR) && (idx < `IOL_FIRST_EXT);
   endfunction

   function automatic logic in_capable(input logic [5:0] idx);
      return line_kind(idx) != IOL_KIND_ISO_OUT;
   endfunction

   function automatic logic out_capable(input logic [5:0] idx);
      iol_kind_e k;
      k = line_kind(idx);
      return (k == IOL_KIND_ISO_OUT) || (k == IOL_KIND_BIDIR);
   endfunction

   // Read-only style of fixed lines; module lines report their written style
   function automatic iol_style_e line_style(input logic [5:0] idx, input logic bal);
      iol_style_e s;
      case (line_kind(idx))
         IOL_KIND_BAL_IN: s = IOL_STYLE_BAL;
         IOL_KIND_ISO_IN: s = IOL_STYLE_OPTO;
         IOL_KIND_ISO_OUT: s = IOL_STYLE_OPTO;
         IOL_KIND_BIDIR: s = (is_ext(idx) && bal) ? IOL_STYLE_BAL : IOL_STYLE_TTL;
         default: s = IOL_STYLE_TTL;
      endcase
      return s;
   endfunction

   // Filter time constant in cycles for a line and a strength step
   function automatic logic [9:0] filter_cycles(input logic [5:0] idx, input logic [2:0] lvl);
      logic [9:0] c;
      if (line_kind(idx) == IOL_KIND_ISO_IN)
      begin
         case (lvl)
            3'h0: c = 10'(`IOL_CYC(`IOL_TC_ISO_0_NS));
            3'h1: c = 10'(`IOL_CYC(`IOL_TC_ISO_1_NS));
            3'h2: c = 10'(`IOL_CYC(`IOL_TC_ISO_2_NS));
            3'h3: c = 10'(`IOL_CYC(`IOL_TC_ISO_3_NS));
            default: c = 10'(`IOL_CYC(`IOL_TC_ISO_4_NS));
         endcase
      end
      else
      begin
         case (lvl)
            3'h0: c = 10'(`IOL_CYC(`IOL_TC_FAST_0_NS));
            3'h1: c = 10'(`IOL_CYC(`IOL_TC_FAST_1_NS));
            3'h2: c = 10'(`IOL_CYC(`IOL_TC_FAST_2_NS));
            3'h3: c = 10'(`IOL_CYC(`IOL_TC_FAST_3_NS));
            default: c = 10'(`IOL_CYC(`IOL_TC_FAST_4_NS));
         endcase
      end
      return c;
   endfunction

   // Source multiplexer; out-of-range indexes and the low group give low
   function automatic logic pick_source(input logic [7:0] choice, input iol_sources_s s);
      logic v;
      logic [5:0] i;
      i = choice[5:0];
      case (iol_src_grp_e'(choice[7:6]))
         IOL_SRC_LOW: v = 1'b0;
         IOL_SRC_USER: v = (32'(i) < NUM_USER) ? s.user_bits[5'(i)] : 1'b0;
         IOL_SRC_STROBE: v = (32'(i) < NUM_STROBE) ? s.strobe[3'(i)] : 1'b0;
         IOL_SRC_TRIG: v = (32'(i) < NUM_TRIG) ? s.cam_trig[3'(i)] : 1'b0;
         default: v = 1'b0;
      endcase
      return v;
   endfunction

   // Register hit for one offset
   function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] ofs);
      return a == ofs;
   endfunction

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   iol_state_s r;
   iol_state_s n;
   logic [39:0] state_word;
   logic acc;
   logic mapped;
   logic [5:0] s;

   // ----------------------------------------------------------------------
   // Logical line state
   // ----------------------------------------------------------------------
   always_comb
   begin
      for (int i = 0; i < `IOL_NUM_LINES; i++)
      begin
         // Input-capable lines show the filtered post_invert_input, output-only the source level
         state_word[i] = in_capable(6'(i)) ? r.filt[i] : r.srclvl[i];
      end
   end

   assign all_lines_state_word = state_word;
   assign pins = r.pins;
   assign s = r.sel;

   // ----------------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------------
   assign acc = psel && penable;
   // Zero wait states; a low enable stretches the access
   assign pready = ce;
   assign mapped = reg_hit(paddr, `IOL_OFS_LINE_SEL) || reg_hit(paddr, `IOL_OFS_LINE_CFG) ||
                   reg_hit(paddr, `IOL_OFS_STATE_LO) || reg_hit(paddr, `IOL_OFS_STATE_HI) ||
                   reg_hit(paddr, `IOL_OFS_LINE_STATE);
   assign pslverr = acc && !mapped;

   always_comb
   begin
      prdata = 32'h0000_0000;
      case (paddr)
         `IOL_OFS_LINE_SEL: prdata[5:0] = r.sel;
         `IOL_OFS_LINE_CFG:
         begin
            prdata[`IOL_CFG_INV_BIT] = r.inv[s];
            prdata[`IOL_CFG_LVL_LSB +: 3] = r.lvl[s];
            prdata[`IOL_CFG_MODE_LSB +: 2] = r.mode[s];
            prdata[`IOL_CFG_BAL_BIT] = r.bal[s];
            prdata[`IOL_CFG_SRC_LSB +: 8] = r.src[s];
            // Style, kind and state are read-only
            prdata[`IOL_CFG_STYLE_LSB +: 2] = line_style(s, r.bal[s]);
            prdata[`IOL_CFG_KIND_LSB +: 2] = line_kind(s);
            prdata[`IOL_CFG_STATE_BIT] = state_word[s];
         end
         `IOL_OFS_STATE_LO: prdata = state_word[31:0];
         `IOL_OFS_STATE_HI: prdata[7:0] = state_word[39:32];
         `IOL_OFS_LINE_STATE: prdata[0] = state_word[s];
         default: prdata = 32'h0000_0000;
      endcase
   end

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb
   begin
      logic inp;
      logic src;
      logic drv;
      logic [9:0] tc;
      logic [2:0] wlvl;
      logic [1:0] wmode;
      logic [7:0] wsrc;
      inp = 1'b0;
      src = 1'b0;
      drv = 1'b0;
      tc = 10'h000;
      wlvl = 3'h0;
      wmode = 2'h0;
      wsrc = 8'h00;
      n = r;
      // Pins enter through two flip-flops
      n.sync1 = rx_pin;
      n.sync2 = r.sync1;

      for (int i = 0; i < `IOL_NUM_LINES; i++)
      begin
         // Input path: inverter then glitch filter
         inp = r.sync2[i] ^ r.inv[i];
         tc = filter_cycles(6'(i), r.lvl[i]);
         // A level that falls back restarts the count, so short glitches vanish
         if (!in_capable(6'(i)) || inp == r.filt[i])
         begin
            n.cnt[i] = 10'h000;
         end
         else if (r.cnt[i] >= tc - 10'h001)
         begin
            n.filt[i] = inp;
            n.cnt[i] = 10'h000;
         end
         else
         begin
            n.cnt[i] = r.cnt[i] + 10'h001;
         end

         // Output path: source mux then inverter
         src = out_capable(6'(i)) ? pick_source(r.src[i], sources) : 1'b0;
         drv = src ^ r.inv[i];
         n.srclvl[i] = src;
         n.pins.tx_level[i] = 1'b0;
         n.pins.tx_oe_n[i] = 1'b1;
         if (line_kind(6'(i)) == IOL_KIND_ISO_OUT)
         begin
            // Level high closes the opto switch
            n.pins.tx_level[i] = drv;
            n.pins.tx_oe_n[i] = 1'b0;
         end
         else if (line_kind(6'(i)) == IOL_KIND_BIDIR)
         begin
            // Sink and source modes release the pin instead of driving the other level
            case (iol_mode_e'(r.mode[i]))
               IOL_MODE_INPUT:
               begin
                  n.pins.tx_oe_n[i] = 1'b1;
               end
               IOL_MODE_OUTPUT:
               begin
                  n.pins.tx_level[i] = drv;
                  n.pins.tx_oe_n[i] = 1'b0;
               end
               IOL_MODE_SINK_ONLY:
               begin
                  n.pins.tx_level[i] = 1'b0;
                  n.pins.tx_oe_n[i] = drv;
               end
               IOL_MODE_SOURCE_ONLY:
               begin
                  n.pins.tx_level[i] = 1'b1;
                  n.pins.tx_oe_n[i] = !drv;
               end
               default:
               begin
                  n.pins.tx_oe_n[i] = 1'b1;
               end
            endcase
         end
      end

      // ----------------------------------------------------------------------
      // Register writes
      // ----------------------------------------------------------------------
      // Refused fields keep their old value and raise no error
      if (acc && pwrite)
      begin
         if (reg_hit(paddr, `IOL_OFS_LINE_SEL))
         begin
            if (pwdata[5:0] < 6'(`IOL_NUM_LINES))
            begin
               n.sel = pwdata[5:0];
            end
         end
         else if (reg_hit(paddr, `IOL_OFS_LINE_CFG))
         begin
            wlvl = pwdata[`IOL_CFG_LVL_LSB +: 3];
            wmode = pwdata[`IOL_CFG_MODE_LSB +: 2];
            wsrc = pwdata[`IOL_CFG_SRC_LSB +: 8];
            n.inv[s] = pwdata[`IOL_CFG_INV_BIT];
            if (in_capable(s) && wlvl <= 3'h4)
            begin
               n.lvl[s] = wlvl;
            end
            if (is_lvttl(s))
            begin
               n.mode[s] = wmode;
            end
            else if (is_ext(s) && wmode <= 2'(IOL_MODE_OUTPUT))
            begin
               n.mode[s] = wmode;
            end
            if (is_ext(s))
            begin
               // Only odd-numbered module lines (even index) can be balanced
               n.bal[s] = pwdata[`IOL_CFG_BAL_BIT] && !s[0];
            end
            if (out_capable(s) && (iol_src_grp_e'(wsrc[7:6]) != IOL_SRC_TRIG || is_lvttl(s)))
            begin
               n.src[s] = wsrc;
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         // Every driver off except the opto switches, which are held open
         r <= '0;
         r.lvl <= {`IOL_NUM_LINES{`IOL_LVL_RST}};
         r.pins.tx_oe_n <= `IOL_OE_N_RST;
      end
      else if (ce)
      begin
         r <= n;
      end
   end

endmodule

// file: test/iol_line_ctrl_chk_sva.sv
// Port-level assertion checker of the I/O line control block
module iol_line_ctrl_chk
   import iol_pkg::*;
(
   // Clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Lines
   input wire iol_sources_s sources,
   input wire logic [39:0] rx_pin,
   input wire iol_pins_s pins,
   input wire logic [39:0] all_lines_state_word
);
   logic mapped;
   assign mapped = paddr inside {12'h000, 12'h004, 12'h008, 12'h00C, 12'h010};
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_access;
      psel && penable && ce;
   endsequence
   sequence s_read_lo;
      s_access ##0 (!pwrite && paddr == 12'h008);
   endsequence
   sequence s_read_hi;
      s_access ##0 (!pwrite && paddr == 12'h00C);
   endsequence
   a_pready_ce: assert property (pready == ce)
      else $error("pready does not follow enable");
   a_unmapped_error: assert property (s_access ##0 !mapped |-> pslverr && (pwrite || prdata == 32'h0))
      else $error("unmapped access without error");
   a_mapped_no_error: assert property (s_access ##0 mapped |-> !pslverr)
      else $error("mapped access flagged as error");
   a_iso_out_driven: assert property (pins.tx_oe_n[15:12] == 4'h0)
      else $error("isolated output not driven");
   a_inputs_undriven: assert property (pins.tx_oe_n[11:0] == 12'hFFF)
      else $error("input-only line driven");
   a_reset_state: assert property ($rose(presetn) |-> pins.tx_oe_n == 40'hFF_FFFF_0FFF && pins.tx_level == 40'h0
      && all_lines_state_word == 40'h0)
      else $error("wrong state after reset");
   a_filter_stable: assert property ($changed(all_lines_state_word[0]) |-> $past(rx_pin[0], 3) == $past(rx_pin[0], 4))
      else $error("filter passed an unsettled input");
   a_ce_freeze: assert property (!ce |=> $stable(pins) && $stable(all_lines_state_word))
      else $error("state moved while enable low");
   a_state_lo_read: assert property (s_read_lo |-> prdata == all_lines_state_word[31:0])
      else $error("low state word read mismatch");
   a_state_hi_read: assert property (s_read_hi |-> prdata == {24'h0, all_lines_state_word[39:32]})
      else $error("high state word read mismatch");
endmodule

bind iol_line_ctrl iol_line_ctrl_chk u_chk (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .sources(sources), .rx_pin(rx_pin), .pins(pins), .all_lines_state_word(all_lines_state_word));

// file: test/iol_line_wiring.sv
// Model of the wiring beyond the line pins
module iol_line_wiring
   import iol_pkg::*;
(
   // From the block
   input wire iol_pins_s pins,
   // Far-side level seen when the block lets go of a line
   input wire logic [39:0] ext,
   // To the block
   output logic [39:0] rx_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   // A driven line reads back the driver, a released one the far side
   assign rx_pin = (pins.tx_oe_n & ext) | (~pins.tx_oe_n & pins.tx_level);
endmodule

// file: test/testbench.sv
// Self-checking testbench of the I/O line control block
module testbench
   import iol_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'h0;
   logic presetn = 1'h0;
   logic ce = 1'h1;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   iol_sources_s src = '0;
   logic [39:0] ext = 40'h0;
   logic [39:0] rx;
   logic [39:0] word;
   iol_pins_s pins;
   logic [31:0] rd;
   logic er;
   int bad_count = 0;
   int n_checks = 0;
   int tcf [5] = '{5, 10, 20, 50, 100};

   always #5 pclk = ~pclk;

   iol_line_ctrl u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sources(src),
      .rx_pin(rx), .pins(pins), .all_lines_state_word(word));
   iol_line_wiring u_wire (.pins(pins), .ext(ext), .rx_pin(rx));

   // ----------------------------------------
   // Bus and compare helpers
   // ----------------------------------------
   task automatic check(input logic [39:0] got, input logic [39:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'h1);
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic cfg(input logic [5:0] ln, input logic [31:0] v);
      apb(1'h1, 12'h000, {26'h0, ln});
      apb(1'h1, 12'h004, v);
      repeat (2) @(posedge pclk);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      logic [3:0] sk [4] = '{4'h0, 4'h5, 4'h9, 4'hE};
      logic [5:0] ln [4] = '{6'h00, 6'h04, 6'h0C, 6'h10};
      check(pins.tx_oe_n, 40'hFF_FFFF_0FFF);
      check(pins.tx_level, 40'h0);
      check(word, 40'h0);
      for (int i = 0; i < 4; i++)
      begin
         apb(1'h1, 12'h000, {26'h0, ln[i]});
         apb(1'h0, 12'h004, 32'h0);
         check(rd[19:0], {sk[i], 16'h0002});
      end
      $display("test reset done");
   endtask

   task automatic t_iso_out();
      logic [31:0] cv [5] = '{32'h4102, 32'h4103, 32'hC003, 32'h8002, 32'h0002};
      logic [1:0] ex [5] = '{2'h3, 2'h1, 2'h1, 2'h3, 2'h0};
      src.user_bits[1] <= 1'h1;
      src.strobe[0] <= 1'h1;
      for (int i = 0; i < 5; i++)
      begin
         cfg(6'h0C, cv[i]);
         check({pins.tx_level[12], word[12]}, ex[i]);
      end
      $display("test isolated output done");
   endtask

   task automatic t_bidir();
      logic drv;
      for (int d = 0; d < 2; d++)
         for (int m = 0; m < 4; m++)
         begin
            drv = d[0];
            src.user_bits[0] <= drv;
            cfg(6'h10, {16'h0, 8'h40, 2'h0, m[1:0], 4'h2});
            check(pins.tx_oe_n[16], (m == 0) ? 1'h1 : (m == 1) ? 1'h0 : (m == 2) ? drv : !drv);
            if (m != 0)
               check(pins.tx_level[16], (m == 1) ? drv : (m == 3));
         end
      src.user_bits[0] <= 1'h1;
      cfg(6'h10, 32'h0000_4022);
      ext[16] <= 1'h1;
      repeat (20) @(posedge pclk);
      check(word[16], 1'h1);
      ext[16] <= 1'h0;
      repeat (20) @(posedge pclk);
      check(word[16], 1'h0);
      cfg(6'h10, 32'h0000_4013);
      repeat (20) @(posedge pclk);
      check({pins.tx_level[16], word[16]}, 2'h1);
      cfg(6'h10, 32'h0000_C012);
      src.cam_trig[0] <= 1'h1;
      repeat (2) @(posedge pclk);
      check(pins.tx_level[16], 1'h1);
      cfg(6'h10, 32'h0000_0002);
      $display("test bidirectional done");
   endtask

   task automatic t_filter(input logic [5:0] ln, input logic [2:0] lv, input int tc);
      int n;
      cfg(ln, {28'h0, lv, 1'h0});
      ext[ln] <= 1'h1;
      repeat (tc - 3) @(posedge pclk);
      ext[ln] <= 1'h0;
      repeat (tc + 5) @(posedge pclk);
      check(word[ln], 1'h0);
      ext[ln] <= 1'h1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (word[ln] !== 1'h1 && n < 2000);
      check(n >= tc && n <= tc + 5, 1'h1);
      repeat (tc) @(posedge pclk);
      ext[ln] <= 1'h0;
      repeat (tc + 10) @(posedge pclk);
      $display("test filter line %0d level %0d done", ln, lv);
   endtask

   task automatic t_bus();
      apb(1'h0, 12'h014, 32'h0);
      check({er, rd}, 33'h1_0000_0000);
      ext[39] <= 1'h1;
      ext[1] <= 1'h1;
      repeat (20) @(posedge pclk);
      apb(1'h0, 12'h00C, 32'h0);
      check({er, rd}, 33'h0_0000_0080);
      apb(1'h0, 12'h008, 32'h0);
      check({er, rd}, 33'h0_0000_0002);
      ce <= 1'h0;
      ext[39] <= 1'h0;
      repeat (30) @(posedge pclk);
      check(word[39], 1'h1);
      ce <= 1'h1;
      repeat (30) @(posedge pclk);
      check(word[39], 1'h0);
      $display("test bus done");
   endtask

   task automatic t_ext();
      cfg(6'h14, 32'h0000_4052);
      apb(1'h0, 12'h004, 32'h0);
      check(rd[19:0], 20'hC_4052);
      check({pins.tx_oe_n[20], pins.tx_level[20]}, 2'h1);
      cfg(6'h15, 32'h0000_4072);
      apb(1'h0, 12'h004, 32'h0);
      check({rd[19:0], pins.tx_oe_n[21]}, 21'h1C_8005);
      repeat (20) @(posedge pclk);
      apb(1'h1, 12'h000, 32'h0000_0014);
      apb(1'h0, 12'h010, 32'h0);
      check(rd, 32'h0000_0001);
      presetn <= 1'h0;
      repeat (2) @(posedge pclk);
      presetn <= 1'h1;
      apb(1'h1, 12'h000, 32'h0000_0014);
      apb(1'h0, 12'h004, 32'h0);
      check(rd[19:0], 20'hE_0002);
      check(pins.tx_oe_n, 40'hFF_FFFF_0FFF);
      $display("test extension lines done");
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (10) @(posedge pclk);
      presetn <= 1'h1;
      t_reset();
      t_iso_out();
      t_bidir();
      for (int i = 0; i < 5; i++)
         t_filter(6'h00, i[2:0], tcf[i]);
      t_filter(6'h04, 3'h0, 50);
      t_filter(6'h04, 3'h4, 1000);
      t_bus();
      t_ext();
      give_verdict();
   end

   initial
   begin
      #200us;
      bad_count++;
      give_verdict();
   end
endmodule
